/* File: hdl/epd_updater_defs.svh */
// constants of the electrophoretic panel serial updater
// ----------------------------------------------------------------
// Contract
// - two link forms, 3-wire and 4-wire, share one command framing.
// - each transaction is one command byte (indicator 0) then data bytes (indicator 1 on writes).
// - 4-wire form carries the indicator on its own pin.
// - 3-wire form uses nine clocks per byte, indicator bit first.
// - 4-wire form keeps the indicator pin low during read data bytes.
// - data byte count is width times height over two to (3 minus depth code).
// - command byte comes from an 8-bit field, sent MSB first.
// - write bytes fetched from, read bytes stored to, the buffer base address.
// - transfer function bit 1 runs a write, 0 runs a read.
// - 3-wire read, indicator enable 0: indicator bit of data bytes not driven.
// - 3-wire read, indicator enable 1: drive first bit 1, release eight bits.
// - timing unit is clock period times (divider plus one).
// - byte pulse option raises select between consecutive data bytes.
// - three 8-bit fields set select width, setup and hold.
// - lines are stepped by a 10-bit stride, wider than width allowed.
// - one bit picks pixel bit order, another picks pixel order in byte.
// - 2-bit orientation field picks the rotation of sent pixels.
// - epaper select 1 enables the updater; 2-bit field picks link form.
// - trigger write 1 starts; completion clears trigger and sets done flag.
// - done flag cleared by writing 1; enable bit gates it onto interrupt.
// ----------------------------------------------------------------
`ifndef EPD_UPDATER_DEFS_SVH
`define EPD_UPDATER_DEFS_SVH
`define EPD_LINK_3WIRE 2'h1
`define EPD_LINK_4WIRE 2'h2
`define EPD_DEPTH_8BPP 2'h3
`define EPD_BITS_3WIRE 4'h9
`define EPD_BITS_4WIRE 4'h8
`define EPD_CLOCK_UNITS 8'h01
`define EPD_ORIENT_FLIP_V 2'h1
`define EPD_ORIENT_FLIP_VH 2'h2
`define EPD_ORIENT_FLIP_H 2'h3
`endif

/* File: hdl/epd_updater_pkg.sv */
// types of the electrophoretic panel serial updater
package epd_updater_pkg;
    typedef struct packed {
        logic epaper_select;
        logic [1:0] link_variant_select;
        logic [1:0] orientation_select;
        logic chip_select_byte_pulse;
        logic read_indicator_enable;
        logic bit_order_select;
        logic pixel_order_select;
        logic pixel_invert;
        logic select_polarity;
        logic transfer_function_select;
        logic [1:0] pixel_depth_code;
        logic [7:0] timing_unit_divider;
        logic [7:0] command_byte_field;
        logic [7:0] select_width_time;
        logic [7:0] select_setup_time;
        logic [7:0] select_hold_time;
        logic [9:0] panel_width;
        logic [9:0] panel_height;
        logic [9:0] line_stride;
        logic [31:0] buffer_base_address;
    } epd_config_type;

    typedef enum logic [7:0] {
        EPD_IDLE = 8'h01,
        EPD_FETCH = 8'h02,
        EPD_SETUP = 8'h04,
        EPD_BIT_LO = 8'h08,
        EPD_BIT_HI = 8'h10,
        EPD_HOLD = 8'h20,
        EPD_GAP = 8'h40,
        EPD_DONE = 8'h80
    } epd_state_type;
endpackage

/* File: hdl/epd_serial_panel_updater.sv */
// electrophoretic panel serial updater: command byte then data bytes
`timescale 1ns/10ps
`include "epd_updater_defs.svh"
module epd_serial_panel_updater (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // configuration and control
    input wire epd_updater_pkg::epd_config_type i_config,
    input wire logic i_trigger_write,
    input wire logic i_flag_clear,
    input wire logic i_update_done_irq_enable,
    // status
    output logic o_update_trigger,
    output logic o_update_done_flag,
    output logic o_irq,
    // internal memory
    output logic [31:0] o_mem_addr,
    output logic o_mem_rd,
    input wire logic i_mem_rvalid,
    input wire logic [7:0] i_mem_rdata,
    output logic o_mem_wr,
    output logic [7:0] o_mem_wdata,
    // panel link
    output logic o_panel_select_n,
    output logic o_panel_clock,
    output logic o_panel_dc,
    output logic o_panel_data,
    output logic o_panel_data_oe,
    input wire logic i_panel_data
);
    import epd_updater_pkg::*;

    // ----------------------------------------------------------------
    // pixel reordering
    // ----------------------------------------------------------------
    // maps frame buffer bit order to sent order; back applies the inverse
    function automatic logic [7:0] epd_order(input logic [7:0] v, input logic [1:0] d,
                                             input logic b, input logic p, input logic back);
        logic [7:0] r;
        int s;
        int n;
        int pi;
        int bi;
        r = 8'h00;
        s = 1 << d;
        n = 8 / s;
        for (int i = 0; i < 8; i++)
        begin
            pi = p ? (n - 1 - i / s) : (i / s);
            bi = b ? (s - 1 - i % s) : (i % s);
            if (back)
                r[pi * s + bi] = v[7 - i];
            else
                r[7 - i] = v[pi * s + bi];
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // state and decode
    // ----------------------------------------------------------------
    epd_config_type cfg;
    epd_state_type state;
    logic [7:0] div_cnt;
    logic [7:0] wait_cnt;
    logic [3:0] bit_cnt;
    logic [8:0] shift;
    logic [7:0] rx;
    logic [9:0] col;
    logic [9:0] line;
    logic is_cmd;
    logic cs_on;
    logic dc;
    logic rd_sent;
    logic gap_pending;

    // unit timing and phase ends
    wire timed = state inside {EPD_SETUP, EPD_BIT_LO, EPD_BIT_HI, EPD_HOLD, EPD_GAP};
    wire tick = timed && (div_cnt == cfg.timing_unit_divider);
    wire phase_end = tick && (wait_cnt <= 8'h01);
    wire start = (state == EPD_IDLE) && i_trigger_write && i_config.epaper_select;
    wire three_wire = (cfg.link_variant_select == `EPD_LINK_3WIRE);
    wire start_3w = (i_config.link_variant_select == `EPD_LINK_3WIRE);
    wire is_write = cfg.transfer_function_select;
    wire rd_data = !is_cmd && !is_write;
    wire first_bit = (bit_cnt == `EPD_BITS_3WIRE);

    // byte geometry: bytes per line from width and depth, lines from height
    wire [9:0] bpl = cfg.panel_width >> (2'h3 - cfg.pixel_depth_code);
    wire no_data = (bpl == 10'h000) || (cfg.panel_height == 10'h000);
    wire last_col = (col == bpl - 10'h001);
    wire last_data = last_col && (line == cfg.panel_height - 10'h001);

    // rotation as mirrored stepping of lines and columns
    wire flip_v = (cfg.orientation_select == `EPD_ORIENT_FLIP_V) ||
                  (cfg.orientation_select == `EPD_ORIENT_FLIP_VH);
    wire flip_h = (cfg.orientation_select == `EPD_ORIENT_FLIP_H) ||
                  (cfg.orientation_select == `EPD_ORIENT_FLIP_VH);
    wire [9:0] line_eff = flip_v ? (cfg.panel_height - 10'h001 - line) : line;
    wire [9:0] col_eff = flip_h ? (bpl - 10'h001 - col) : col;
    wire [19:0] line_off = line_eff * cfg.line_stride;
    wire [31:0] addr_calc = cfg.buffer_base_address + {12'h000, line_off} + {22'h0, col_eff};
    wire pix_p = cfg.pixel_order_select ^ flip_h;

    // byte ordering for sent and received data
    wire [7:0] tx_byte = epd_order(i_mem_rdata ^ {8{cfg.pixel_invert}}, cfg.pixel_depth_code,
                                   cfg.bit_order_select, pix_p, 1'b0);
    wire [7:0] rx_in = {rx[6:0], i_panel_data};
    wire [7:0] rx_byte = epd_order(rx_in, cfg.pixel_depth_code, cfg.bit_order_select, pix_p, 1'b1);

    // ----------------------------------------------------------------
    // panel pins
    // ----------------------------------------------------------------
    // polarity 0 gives active-low select
    assign o_panel_select_n = cs_on ? cfg.select_polarity : !cfg.select_polarity;
    assign o_panel_clock = (state == EPD_BIT_HI);
    assign o_panel_dc = three_wire ? 1'b0 : dc;
    // read data bits are released; only the indicator bit may be driven
    assign o_panel_data_oe = cs_on && (!rd_data || (three_wire && first_bit && cfg.read_indicator_enable));
    assign o_panel_data = shift[8] && o_panel_data_oe;
    assign o_irq = o_update_done_flag && i_update_done_irq_enable;

    // ----------------------------------------------------------------
    // timing unit divider
    // ----------------------------------------------------------------
    // restarts on every phase so each phase is whole units
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
            div_cnt <= 8'h00;
        else if (tick || !timed)
            div_cnt <= 8'h00;
        else
            div_cnt <= div_cnt + 8'h01;
    end

    // ----------------------------------------------------------------
    // trigger and done flag
    // ----------------------------------------------------------------
    // a done event in the clearing cycle keeps the flag set
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_update_trigger <= 1'b0;
            o_update_done_flag <= 1'b0;
        end
        else
        begin
            if (start)
                o_update_trigger <= 1'b1;
            else if (state == EPD_DONE)
                o_update_trigger <= 1'b0;
            if (state == EPD_DONE)
                o_update_done_flag <= 1'b1;
            else if (i_flag_clear)
                o_update_done_flag <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // transaction sequencer
    // ----------------------------------------------------------------
    // config is latched at start so software edits cannot tear a frame
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            cfg <= '0;
            state <= EPD_IDLE;
            wait_cnt <= 8'h00;
            bit_cnt <= 4'h0;
            shift <= 9'h000;
            rx <= 8'h00;
            col <= 10'h000;
            line <= 10'h000;
            is_cmd <= 1'b0;
            cs_on <= 1'b0;
            dc <= 1'b0;
            rd_sent <= 1'b0;
            gap_pending <= 1'b0;
            o_mem_addr <= 32'h00000000;
            o_mem_rd <= 1'b0;
            o_mem_wr <= 1'b0;
            o_mem_wdata <= 8'h00;
        end
        else
        begin
            o_mem_rd <= 1'b0;
            o_mem_wr <= 1'b0;
            if (tick && !phase_end)
                wait_cnt <= wait_cnt - 8'h01;
            case (state)
                EPD_IDLE:
                    if (start)
                    begin
                        cfg <= i_config;
                        is_cmd <= 1'b1;
                        dc <= 1'b0;
                        col <= 10'h000;
                        line <= 10'h000;
                        // 3-wire: indicator first, then command MSB first; 4-wire: command MSB first
                        shift <= start_3w ? {1'b0, i_config.command_byte_field}
                                          : {i_config.command_byte_field, 1'b0};
                        bit_cnt <= start_3w ? `EPD_BITS_3WIRE : `EPD_BITS_4WIRE;
                        cs_on <= 1'b1;
                        wait_cnt <= i_config.select_setup_time;
                        state <= EPD_SETUP;
                    end
                EPD_FETCH:
                    if (is_write && !rd_sent)
                    begin
                        o_mem_rd <= 1'b1;
                        o_mem_addr <= addr_calc;
                        rd_sent <= 1'b1;
                    end
                    else if (!is_write || i_mem_rvalid)
                    begin
                        rd_sent <= 1'b0;
                        dc <= is_write;
                        shift <= three_wire ? {1'b1, is_write ? tx_byte : 8'h00}
                                            : {is_write ? tx_byte : 8'h00, 1'b0};
                        bit_cnt <= three_wire ? `EPD_BITS_3WIRE : `EPD_BITS_4WIRE;
                        cs_on <= 1'b1;
                        wait_cnt <= cs_on ? `EPD_CLOCK_UNITS : cfg.select_setup_time;
                        state <= cs_on ? EPD_BIT_LO : EPD_SETUP;
                    end
                EPD_SETUP:
                    if (phase_end)
                    begin
                        wait_cnt <= `EPD_CLOCK_UNITS;
                        state <= EPD_BIT_LO;
                    end
                EPD_BIT_LO:
                    if (phase_end)
                    begin
                        wait_cnt <= `EPD_CLOCK_UNITS;
                        state <= EPD_BIT_HI;
                    end
                EPD_BIT_HI:
                    if (phase_end)
                    begin
                        rx <= rx_in;
                        wait_cnt <= `EPD_CLOCK_UNITS;
                        if (bit_cnt > 4'h1)
                        begin
                            shift <= {shift[7:0], 1'b0};
                            bit_cnt <= bit_cnt - 4'h1;
                            state <= EPD_BIT_LO;
                        end
                        else
                        begin
                            if (rd_data)
                            begin
                                o_mem_wr <= 1'b1;
                                o_mem_addr <= addr_calc;
                                o_mem_wdata <= rx_byte;
                            end
                            if (!is_cmd)
                            begin
                                col <= last_col ? 10'h000 : col + 10'h001;
                                line <= last_col ? line + 10'h001 : line;
                            end
                            is_cmd <= 1'b0;
                            gap_pending <= !is_cmd && cfg.chip_select_byte_pulse;
                            if ((is_cmd && no_data) || (!is_cmd && last_data))
                            begin
                                gap_pending <= 1'b0;
                                wait_cnt <= cfg.select_hold_time;
                                state <= EPD_HOLD;
                            end
                            else if (!is_cmd && cfg.chip_select_byte_pulse)
                            begin
                                wait_cnt <= cfg.select_hold_time;
                                state <= EPD_HOLD;
                            end
                            else
                                state <= EPD_FETCH;
                        end
                    end
                EPD_HOLD:
                    if (phase_end)
                    begin
                        cs_on <= 1'b0;
                        wait_cnt <= cfg.select_width_time;
                        state <= gap_pending ? EPD_GAP : EPD_DONE;
                    end
                EPD_GAP:
                    if (phase_end)
                        state <= EPD_FETCH;
                EPD_DONE:
                    state <= EPD_IDLE;
                default:
                    state <= EPD_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [8:0] hi_len;
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
            hi_len <= 9'h000;
        else
            hi_len <= o_panel_clock ? hi_len + 9'h001 : 9'h000;
    end

    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    AST_DONE_CLEARS_TRIGGER: assert property (state == EPD_DONE |=> !o_update_trigger && o_update_done_flag)
        else $error("done did not clear trigger or set flag");
    AST_SET_BEATS_CLEAR: assert property (state == EPD_DONE && i_flag_clear |=> o_update_done_flag)
        else $error("done flag lost to clear");
    AST_IRQ_FOLLOWS_FLAG: assert property ($rose(o_update_done_flag) && i_update_done_irq_enable |-> o_irq)
        else $error("enabled done flag gave no interrupt");
    AST_CMD_DC_LOW: assert property (is_cmd && o_panel_clock |-> o_panel_dc == 1'b0)
        else $error("indicator not low on command byte");
    AST_WRITE_DC_HIGH: assert property (!three_wire && !is_cmd && is_write && o_panel_clock |-> o_panel_dc)
        else $error("indicator pin not high on write data");
    AST_READ_DC_LOW: assert property (!three_wire && rd_data |-> !o_panel_dc)
        else $error("indicator pin rose on read data");
    AST_READ_RELEASED: assert property (rd_data && !first_bit && cs_on |-> !o_panel_data_oe)
        else $error("data driven during read bits");
    AST_INDICATOR_BIT: assert property (three_wire && rd_data && first_bit && state == EPD_BIT_HI
                                        |-> o_panel_data_oe == cfg.read_indicator_enable)
        else $error("read indicator bit drive wrong");
    AST_CLOCK_HIGH_UNIT: assert property ($fell(o_panel_clock) |-> hi_len == {1'b0, cfg.timing_unit_divider} + 9'h001)
        else $error("clock high not one timing unit");
    AST_SELECT_WHILE_CLOCK: assert property (o_panel_clock |-> o_panel_select_n == cfg.select_polarity)
        else $error("select inactive while clocking");
    AST_READ_STROBE_SINGLE: assert property (o_mem_rd |=> !o_mem_rd ##1 !o_mem_rd)
        else $error("memory read strobe too long");
    COV_WRITE_DONE: cover property (state == EPD_DONE && is_write);
    COV_READ_DONE: cover property (state == EPD_DONE && !is_write);
    COV_BYTE_GAP: cover property (state == EPD_GAP ##[1:600] state == EPD_SETUP);
endmodule

/* File: test/epd_panel_model.sv */
// behavioural panel on the serial link: records bits, answers reads
`timescale 1ns/10ps
module epd_panel_model (
    // link from the updater
    input wire logic i_select_n,
    input wire logic i_clock_line,
    input wire logic i_dc,
    input wire logic i_data,
    input wire logic i_data_oe,
    input wire logic i_three_wire,
    // reply line
    output logic o_data
);
    localparam logic [7:0] REPLY = 8'hB4;
    logic [2:0] seen [$];
    int edges;
    int falls;
    int pos;
    time rise_at;
    time high_ns;
    logic last;
    initial
    begin
        o_data = 1'b1;
        last = 1'b0;
        edges = 0;
        falls = 0;
        rise_at = 0;
        high_ns = 0;
    end
    task automatic clear();
        seen.delete();
        edges = 0;
        falls = 0;
    endtask
    // frames counted per select fall
    always @(negedge i_select_n) falls++;
    // released line shows the inverse of the last value, never a stale one
    always @(posedge i_select_n) o_data = ~last;
    // capture {indicator pin, data, enable} while selected
    always @(posedge i_clock_line)
    begin
        if (!i_select_n)
        begin
            seen.push_back({i_dc, i_data, i_data_oe});
            edges++;
            rise_at = $time;
        end
    end
    // reply bits change at the start of clock low; 9 or 8 clocks per byte
    always @(negedge i_clock_line)
    begin
        if (!i_select_n)
        begin
            high_ns = $time - rise_at;
            pos = edges % (i_three_wire ? 9 : 8);
            if (edges >= (i_three_wire ? 9 : 8) && !(i_three_wire && pos == 0))
                last = REPLY[7 - (pos - (i_three_wire ? 1 : 0))];
            else
                last = ~last;
            o_data = last;
        end
    end
endmodule

/* File: test/tb_top.sv */
// self-checking bench of the panel serial updater
`timescale 1ns/10ps
`include "epd_updater_defs.svh"
module tb_top;
    import epd_updater_pkg::*;
    logic i_clock = 1'b0;
    logic i_reset_n = 1'b0;
    logic trig = 1'b0;
    logic fclr = 1'b0;
    logic irq_en = 1'b1;
    logic rvalid = 1'b0;
    logic [7:0] rdata = 8'h00;
    // orientation and inversion applied by the next run
    logic [1:0] rot = 2'h0;
    logic inv = 1'b0;
    epd_config_type cfg = '0;
    logic [7:0] mem [0:63];
    logic upd, flag, irq, mrd, mwr, sel_n, pclk, pdc, pdat, poe, mdl_data;
    logic [31:0] maddr;
    logic [7:0] mwdata;
    wire pin = poe ? pdat : mdl_data;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    epd_serial_panel_updater DUT (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_config(cfg),
        .i_trigger_write(trig), .i_flag_clear(fclr), .i_update_done_irq_enable(irq_en),
        .o_update_trigger(upd), .o_update_done_flag(flag), .o_irq(irq), .o_mem_addr(maddr),
        .o_mem_rd(mrd), .i_mem_rvalid(rvalid), .i_mem_rdata(rdata), .o_mem_wr(mwr),
        .o_mem_wdata(mwdata), .o_panel_select_n(sel_n), .o_panel_clock(pclk), .o_panel_dc(pdc),
        .o_panel_data(pdat), .o_panel_data_oe(poe), .i_panel_data(pin));
    epd_panel_model PANEL (.i_select_n(sel_n), .i_clock_line(pclk), .i_dc(pdc), .i_data(pdat),
        .i_data_oe(poe), .i_three_wire(cfg.link_variant_select == `EPD_LINK_3WIRE), .o_data(mdl_data));
    initial
    begin
        forever #4 i_clock = ~i_clock;
    end
    // internal memory: answers a fetch one cycle late, stores without handshake
    always @(posedge i_clock)
    begin
        rvalid <= mrd;
        if (mrd)
            rdata <= mem[maddr[5:0]];
        if (mwr)
            mem[maddr[5:0]] <= mwdata;
        cycles++;
        if (cycles == 30000)
        begin
            num_errors++;
            test_done();
        end
    end
    task automatic test_done();
        if (num_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] byte_at(input int k, input int per);
        logic [7:0] v;
        for (int i = 0; i < 8; i++)
            v[7 - i] = PANEL.seen[k * per + per - 8 + i][1];
        return v;
    endfunction
    function automatic logic [7:0] rev8(input logic [7:0] x);
        logic [7:0] v;
        for (int i = 0; i < 8; i++)
            v[i] = x[7 - i];
        return v;
    endfunction
    // one transaction: clear flag, program, trigger, wait for the trigger bit to drop
    task automatic run(input logic wr, input logic [1:0] link, input logic [1:0] depth, input logic [9:0] w,
        input logic [9:0] h, input logic [9:0] stride, input logic [7:0] base, input logic [7:0] cmd,
        input logic b, input logic p, input logic pulse, input logic rie, input logic [7:0] div, input logic en);
        epd_config_type c;
        c = '0;
        c.epaper_select = en;
        c.link_variant_select = link;
        c.transfer_function_select = wr;
        c.pixel_depth_code = depth;
        c.panel_width = w;
        c.panel_height = h;
        c.line_stride = stride;
        c.buffer_base_address = {24'h000000, base};
        c.command_byte_field = cmd;
        c.bit_order_select = b;
        c.pixel_order_select = p;
        c.chip_select_byte_pulse = pulse;
        c.read_indicator_enable = rie;
        c.timing_unit_divider = div;
        c.select_polarity = 1'b0;
        c.orientation_select = rot;
        c.pixel_invert = inv;
        @(posedge i_clock);
        cfg <= c;
        fclr <= 1'b1;
        PANEL.clear();
        @(posedge i_clock);
        fclr <= 1'b0;
        trig <= 1'b1;
        @(posedge i_clock);
        trig <= 1'b0;
        repeat (2) @(posedge i_clock);
        for (int n = 0; n < 20000 && upd === 1'b1; n++)
            @(posedge i_clock);
        check("trigger dropped", 0, upd);
        @(posedge i_clock);
    endtask
    initial
    begin
        for (int i = 0; i < 64; i++)
            mem[i] = 8'h1D * i[7:0] + 8'h07;
        repeat (20) @(posedge i_clock);
        i_reset_n <= 1'b1;
        @(posedge i_clock);
        // 4-wire write, 4 bpp, two lines through a stride of 5, unit of 3 cycles
        run(1'b1, `EPD_LINK_4WIRE, 2'h2, 10'h004, 10'h002, 10'h005, 8'h08, 8'h3C, 1'b1, 1'b1, 1'b0, 1'b0, 8'h02, 1'b1);
        check("bit count", 40, PANEL.seen.size());
        check("command", 8'h3C, byte_at(0, 8));
        check("command dc", 0, PANEL.seen[0][2]);
        for (int k = 8; k < 40; k++)
            check("data dc", 1, PANEL.seen[k][2]);
        check("byte 1", mem[8], byte_at(1, 8));
        check("byte 2", mem[9], byte_at(2, 8));
        check("byte 3", mem[13], byte_at(3, 8));
        check("byte 4", mem[14], byte_at(4, 8));
        check("clock high ns", 24, PANEL.high_ns);
        check("trigger", 0, upd);
        check("flag", 1, flag);
        check("irq", 1, irq);
        fclr <= 1'b1;
        @(posedge i_clock);
        fclr <= 1'b0;
        @(posedge i_clock);
        check("flag cleared", 0, flag);
        // 3-wire write, 8 bpp with reversed bits, select pulsed between data bytes
        irq_en <= 1'b0;
        run(1'b1, `EPD_LINK_3WIRE, `EPD_DEPTH_8BPP, 10'h002, 10'h001, 10'h002, 8'h14, 8'hA1, 1'b0, 1'b1, 1'b1, 1'b0,
            8'h00, 1'b1);
        check("bit count 3w", 27, PANEL.seen.size());
        for (int k = 0; k < 3; k++)
            check("indicator bit", k != 0, PANEL.seen[k * 9][1]);
        check("command 3w", 8'hA1, byte_at(0, 9));
        check("byte 1 3w", rev8(mem[20]), byte_at(1, 9));
        check("byte 2 3w", rev8(mem[21]), byte_at(2, 9));
        check("select falls", 2, PANEL.falls);
        check("irq masked", 0, irq);
        irq_en <= 1'b1;
        // 4-wire read: indicator pin stays low, bytes land at the base
        run(1'b0, `EPD_LINK_4WIRE, `EPD_DEPTH_8BPP, 10'h002, 10'h001, 10'h002, 8'h28, 8'h5E, 1'b1, 1'b1, 1'b0, 1'b0,
            8'h01, 1'b1);
        check("bit count rd", 24, PANEL.seen.size());
        for (int k = 0; k < 24; k++)
            check("read dc", 0, PANEL.seen[k][2]);
        check("stored 0", 8'hB4, mem[40]);
        check("stored 1", 8'hB4, mem[41]);
        // 3-wire reads with and without the driven indicator bit
        for (int r = 0; r < 2; r++)
        begin
            run(1'b0, `EPD_LINK_3WIRE, `EPD_DEPTH_8BPP, 10'h001, 10'h001, 10'h001, 8'h32 + r[7:0], 8'h77, 1'b1, 1'b1,
                1'b0, r[0], 8'h00, 1'b1);
            check("indicator oe", r, PANEL.seen[9][0]);
            check("indicator value", r, PANEL.seen[9][1] & PANEL.seen[9][0]);
            for (int k = 10; k < 18; k++)
                check("released oe", 0, PANEL.seen[k][0]);
            check("stored 3w", 8'hB4, mem[50 + r]);
        end
        // 4-wire write turned by 180 degrees, inverted: lines and columns run backwards
        rot = 2'h2;
        inv = 1'b1;
        run(1'b1, `EPD_LINK_4WIRE, `EPD_DEPTH_8BPP, 10'h002, 10'h002, 10'h002, 8'h10, 8'h42, 1'b1, 1'b1, 1'b0, 1'b0,
            8'h00, 1'b1);
        for (int k = 0; k < 4; k++)
            check("turned byte", mem[19 - k] ^ 8'hFF, byte_at(k + 1, 8));
        rot = 2'h0;
        inv = 1'b0;
        // trigger with the panel interface deselected is ignored
        run(1'b1, `EPD_LINK_4WIRE, `EPD_DEPTH_8BPP, 10'h001, 10'h001, 10'h001, 8'h00, 8'h11, 1'b1, 1'b1, 1'b0, 1'b0,
            8'h00, 1'b0);
        check("refused frame", 0, PANEL.seen.size());
        check("refused flag", 0, flag);
        test_done();
    end
endmodule
